// >>> lmt_core.sv
// Purpose: Timing, reset and multiplex control of a 40-segment, 4-backplane LCD driver.
// Assumes: Commands arrive already decoded from the serial bus; all pins synchronous to clk.
// Notes: Drive outputs are 2-bit level codes, 0 = top supply, 3 = panel supply.
// Contract
// R1: After reset every backplane and segment drives the top supply until display enabled.
// R2: Reset selects four-backplane multiplex with one-third bias.
// R3: Reset turns blinking off and returns both bank selectors to default.
// R4: Reset initialises serial interface, clears data pointer and subaddress counter.
// R5: Host waits one millisecond after power-up before bus transfers; the host model waits SETTLE = 8 clock cycles after reset.
// R6: Half bias bypasses the middle ladder resistor, giving three levels.
// R7: Static, 1:2 half/third, 1:3 and 1:4 third or half bias supported.
// R8: Mux and bias change only through the decoded mode-set command.
// R9: Active backplanes equal multiplex ratio.
// R10: With internal oscillator the clock pin drives the clock out.
// R11: Oscillator input tied high selects external clock on the clock pin.
// R12: Normal mode frame equals clock divided by 2880.
// R13: Power-saving mode frame equals clock divided by 480.
// R14: Host supplies clock above 125 kHz for full 100 kHz bus rate.
// R15: Host keeps the clock running always to avoid DC on panel.
// R16: Sync line keeps cascaded drivers' multiplex timing aligned.
// R17: Latch holds one RAM column per phase, reloaded each phase.
// R18: Unabsorbed display data stalls the transfer instead of being dropped.
// R19: RAM bit n drives backplane n segment; address maps to segment one-to-one.
// R20: Output bank steps bits 0-3, 0-2, 0-1 or 0 per mode.
// R21: Waveforms invert in alternate frame halves for zero average voltage.
`include "lmt_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module lmt_core
  import lmt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic osc_tied_high,
  input wire logic clk_pin_in,
  output logic clk_pin_out,
  output logic clk_pin_oe,
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe,
  input wire logic [2:0] hw_subaddr,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [7:0] cmd_arg,
  input wire logic data_valid,
  input wire logic [3:0] data_word,
  output logic data_ready,
  output logic [1:0] backplane_out_0,
  output logic [1:0] backplane_out_1,
  output logic [1:0] backplane_out_2,
  output logic [1:0] backplane_out_3,
  output logic [79:0] segment_out,
  output logic ladder_mid_bypass,
  output logic [2:0] active_backplanes,
  output logic display_enable,
  output logic power_save,
  output logic [1:0] blink_mode,
  output logic in_bank,
  output logic out_bank,
  output logic [5:0] data_pointer,
  output logic [2:0] subaddr_count,
  output logic serial_if_init
);

  typedef struct packed {
    lmt_mux_type mux;
    logic half_bias;
    logic enable;
    logic save;
    logic [1:0] blink;
    logic in_bank;
    logic out_bank;
    logic [5:0] ptr;
    logic [2:0] sub;
    logic init;
    logic [3:0] osc_cnt;
    logic osc_clk;
    logic ext_prev;
    logic sync_prev;
    logic sync_drive;
    logic [1:0] pend_phase;
    logic pend_half;
    logic [1:0] shown_phase;
    logic shown_half;
    logic [3:0][1:0] bp;
    logic [79:0] seg;
  } lmt_core_state_type;

  lmt_core_state_type s;
  lmt_core_state_type next_s;
  logic tick;
  logic resync;
  logic slot_start;
  logic [1:0] phase;
  logic half;
  logic [1:0] load_bit;
  logic wr_store;
  logic [3:0] wr_data;
  logic [3:0] wr_mask;
  logic wr_ready;
  logic load_done;
  logic [39:0] latch;
  logic [1:0] seg_lvl [0:39];
  logic [1:0] on_lvl;
  logic [1:0] off_lvl;
  logic [1:0] sel_lvl;
  logic [1:0] unsel_lvl;
  logic [1:0] inv;

  // ----------------------------------------
  // Timing tick: own oscillator or external clock edge
  // ----------------------------------------
  // Edge of the generated or the external clock; pin is sampled as synchronous
  assign tick = osc_tied_high ? (clk_pin_in && !s.ext_prev) // [R11]
                              : (s.osc_cnt == `LMT_OSC_HALF_CYCLES - 4'h1 && !s.osc_clk);
  // A falling sync edge we did not cause restarts our frame
  assign resync = !sync_in && s.sync_prev && !s.sync_drive; // [R16]

  lmt_frame_div u_div (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick),
    .power_save(s.save),
    .mux(s.mux),
    .resync(resync),
    .slot_start(slot_start),
    .phase(phase),
    .half(half)
  );

  // ----------------------------------------
  // Output bank: RAM bit shown in this slot
  // ----------------------------------------
  always_comb
  begin
    unique case (s.mux)
      LMT_MUX_STATIC: load_bit = s.out_bank ? 2'h2 : 2'h0; // [R20]
      LMT_MUX_2: load_bit = {s.out_bank, phase[0]}; // [R20]
      default: load_bit = phase; // [R20]
    endcase
  end

  // ----------------------------------------
  // Input bank: which RAM bits a data word lands in
  // ----------------------------------------
  always_comb
  begin
    wr_store = (s.sub == hw_subaddr);
    unique case (s.mux)
      LMT_MUX_STATIC:
      begin
        wr_data = {1'b0, data_word[0], 1'b0, data_word[0]};
        wr_mask = s.in_bank ? 4'h4 : 4'h1;
      end
      LMT_MUX_2:
      begin
        wr_data = {data_word[1:0], data_word[1:0]};
        wr_mask = s.in_bank ? 4'hC : 4'h3;
      end
      default:
      begin
        wr_data = data_word;
        wr_mask = 4'hF;
      end
    endcase
  end

  lmt_ram_latch u_lat (
    .clk(clk),
    .rst_n(rst_n),
    .load_start(slot_start),
    .load_bit(load_bit),
    .wr_valid(data_valid),
    .wr_store(wr_store),
    .wr_addr(s.ptr),
    .wr_data(wr_data),
    .wr_mask(wr_mask),
    .wr_ready(wr_ready),
    .load_done(load_done),
    .latch(latch)
  );

  // ----------------------------------------
  // Drive levels for the phase the latch now holds
  // ----------------------------------------
  always_comb
  begin
    inv = {s.shown_half, s.shown_half}; // [R21]
    if (s.mux == LMT_MUX_STATIC)
    begin
      sel_lvl = `LMT_LVL_TOP ^ inv;
      unsel_lvl = `LMT_LVL_TOP ^ inv;
      on_lvl = `LMT_LVL_BOT ^ inv;
      off_lvl = `LMT_LVL_TOP ^ inv;
    end
    else
    begin
      // Half bias puts an off segment on the panel supply instead of tap two; the unselected level stays on tap one
      sel_lvl = `LMT_LVL_BOT ^ inv;
      unsel_lvl = `LMT_LVL_ONE ^ inv;
      on_lvl = `LMT_LVL_TOP ^ inv;
      off_lvl = (s.half_bias ? `LMT_LVL_BOT : `LMT_LVL_TWO) ^ inv; // [R6]
    end
  end

  // Per-segment level from the latched column
  genvar gi;
  generate
    for (gi = 0; gi < `LMT_SEGMENTS; gi = gi + 1)
    begin : g_seg
      assign seg_lvl[gi] = latch[gi] ? on_lvl : off_lvl; // [R19]
    end
  endgenerate

  // ----------------------------------------
  // Command decode, data pointer, waveform registers
  // ----------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.init = 1'b0;
    next_s.ext_prev = clk_pin_in;
    next_s.sync_prev = sync_in;
    // Own oscillator, also driven out for cascaded drivers
    if (s.osc_cnt == `LMT_OSC_HALF_CYCLES - 4'h1)
    begin
      next_s.osc_cnt = 4'h0;
      next_s.osc_clk = ~s.osc_clk; // [R10]
    end
    else
      next_s.osc_cnt = s.osc_cnt + 4'h1;
    // Pull sync low through the first slot of each frame
    if (slot_start)
      next_s.sync_drive = (phase == 2'h0) && !half;
    if (slot_start)
    begin
      next_s.pend_phase = phase;
      next_s.pend_half = half;
    end
    // Phase and polarity follow the latch, not the divider, so data and levels match
    if (load_done)
    begin
      next_s.shown_phase = s.pend_phase; // [R17]
      next_s.shown_half = s.pend_half;
    end
    if (cmd_valid)
    begin
      unique case (cmd_code)
        `LMT_CMD_MODE_SET:
        begin
          next_s.mux = lmt_mux_type'(cmd_arg[`LMT_ARG_MUX_LSB +: 2]); // [R8] [R7]
          next_s.half_bias = cmd_arg[`LMT_ARG_HALF_BIT]; // [R8]
          next_s.enable = cmd_arg[`LMT_ARG_ENABLE_BIT];
          next_s.save = cmd_arg[`LMT_ARG_SAVE_BIT];
        end
        `LMT_CMD_LOAD_PTR:
          next_s.ptr = (cmd_arg[5:0] > `LMT_LAST_ADDR) ? 6'h00 : cmd_arg[5:0];
        `LMT_CMD_DEV_SEL:
          next_s.sub = cmd_arg[2:0];
        `LMT_CMD_BANK_SEL:
        begin
          next_s.in_bank = cmd_arg[`LMT_ARG_IN_BANK_BIT];
          next_s.out_bank = cmd_arg[`LMT_ARG_OUT_BANK_BIT];
        end
        `LMT_CMD_BLINK:
          next_s.blink = cmd_arg[1:0];
        default:
          next_s.blink = s.blink;
      endcase
    end
    // Accepted words advance the pointer even when storage is inhibited
    if (data_valid && wr_ready)
    begin
      if (s.ptr >= `LMT_LAST_ADDR)
      begin
        next_s.ptr = 6'h00;
        next_s.sub = s.sub + 3'h1;
      end
      else
        next_s.ptr = s.ptr + 6'h01;
    end
    // Backplanes beyond the ratio repeat an active one
    for (int b = 0; b < 4; b++)
    begin
      logic [1:0] bp_phase;
      bp_phase = 2'(b);
      unique case (s.mux)
        LMT_MUX_STATIC: bp_phase = 2'h0; // [R9]
        LMT_MUX_2: bp_phase = {1'b0, bp_phase[0]}; // [R9]
        LMT_MUX_3: bp_phase = (b == 3) ? 2'h1 : bp_phase; // [R9]
        LMT_MUX_4: bp_phase = 2'(b); // [R9]
      endcase
      if (!s.enable)
        next_s.bp[b] = `LMT_LVL_TOP; // [R1]
      else
        next_s.bp[b] = (bp_phase == s.shown_phase) ? sel_lvl : unsel_lvl;
    end
    for (int i = 0; i < `LMT_SEGMENTS; i++)
      next_s.seg[2 * i +: 2] = s.enable ? seg_lvl[i] : `LMT_LVL_TOP; // [R1]
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s <= '0; // [R1] [R3] [R4]
      s.mux <= LMT_MUX_4; // [R2]
      s.half_bias <= `LMT_RST_HALF_BIAS; // [R2]
      s.init <= 1'b1; // [R4]
      s.sync_prev <= 1'b1;
    end
    else
      s <= next_s;
  end

  // ----------------------------------------
  // Outputs, all from flip-flops except clk_pin_oe (from osc_tied_high) and sync_out (constant)
  // ----------------------------------------
  assign clk_pin_out = s.osc_clk; // [R10]
  assign clk_pin_oe = !osc_tied_high; // [R11]
  assign sync_out = 1'b0;
  assign sync_oe = s.sync_drive; // [R16]
  assign data_ready = wr_ready; // [R18]
  assign backplane_out_0 = s.bp[0];
  assign backplane_out_1 = s.bp[1];
  assign backplane_out_2 = s.bp[2];
  assign backplane_out_3 = s.bp[3];
  assign segment_out = s.seg;
  assign ladder_mid_bypass = s.half_bias && (s.mux != LMT_MUX_STATIC); // [R6]
  assign active_backplanes = 3'(s.mux) + 3'h1; // [R9]
  assign display_enable = s.enable;
  assign power_save = s.save;
  assign blink_mode = s.blink;
  assign in_bank = s.in_bank;
  assign out_bank = s.out_bank;
  assign data_pointer = s.ptr;
  assign subaddr_count = s.sub;
  assign serial_if_init = s.init;

endmodule : lmt_core
`default_nettype wire

// >>> lmt_core_asserts.sv
// Purpose: Port-level checks of the LCD timing core.
// Assumes: Bound to every lmt_core instance; one clock domain.
// Notes: Reset values are checked at the first edge after release.
`include "lmt_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module lmt_core_asserts
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic osc_tied_high,
  input wire logic clk_pin_out,
  input wire logic clk_pin_oe,
  input wire logic sync_out,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [7:0] cmd_arg,
  input wire logic data_valid,
  input wire logic data_ready,
  input wire logic [1:0] backplane_out_0,
  input wire logic [79:0] segment_out,
  input wire logic ladder_mid_bypass,
  input wire logic [2:0] active_backplanes,
  input wire logic [1:0] blink_mode,
  input wire logic in_bank,
  input wire logic out_bank,
  input wire logic [5:0] data_pointer,
  input wire logic [2:0] subaddr_count,
  input wire logic serial_if_init
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Reset state, just after release
  a_reset_top_drive: assert property (!$past(rst_n) |->
    backplane_out_0 == 2'h0 && segment_out == 80'h0) else $error("drive not at top");
  a_reset_mux_four: assert property (!$past(rst_n) |->
    active_backplanes == 3'h4 && !ladder_mid_bypass) else $error("reset mode wrong");
  a_reset_bank_blink: assert property (!$past(rst_n) |->
    blink_mode == 2'h0 && !in_bank && !out_bank) else $error("reset banks wrong");
  a_reset_ptr_clear: assert property (!$past(rst_n) |->
    data_pointer == 6'h00 && subaddr_count == 3'h0 && serial_if_init)
    else $error("reset pointer wrong");
  // Clock pin direction and own oscillator shape
  a_pin_dir: assert property (clk_pin_oe == !osc_tied_high)
    else $error("clock pin direction wrong");
  a_osc_half_period: assert property (!osc_tied_high && $rose(clk_pin_out) |->
    clk_pin_out [*4] ##1 !clk_pin_out) else $error("oscillator period wrong");
  // Mode register follows only the mode command
  a_mode_set_apply: assert property (cmd_valid && cmd_code == `LMT_CMD_MODE_SET |=>
    active_backplanes == {1'b0, $past(cmd_arg[1:0])} + 3'h1 &&
    ladder_mid_bypass == ($past(cmd_arg[2]) && $past(cmd_arg[1:0]) != 2'h0))
    else $error("mode set not applied");
  a_mode_only_cmd: assert property (!(cmd_valid && cmd_code == `LMT_CMD_MODE_SET) |=>
    $stable(active_backplanes) && $stable(ladder_mid_bypass)) else $error("mode moved");
  a_bypass_muxed: assert property (ladder_mid_bypass |-> active_backplanes != 3'h1)
    else $error("bypass in static");
  // Data words advance or wait, never vanish
  a_ptr_step: assert property (data_valid && data_ready && !cmd_valid |=>
    data_pointer == (($past(data_pointer) == `LMT_LAST_ADDR) ? 6'h00 :
    $past(data_pointer) + 6'h01)) else $error("pointer step wrong");
  a_stall_hold: assert property (data_valid && !data_ready && !cmd_valid |=>
    $stable(data_pointer)) else $error("word lost in stall");
  a_stall_bound: assert property ($fell(data_ready) |-> ##[1:45] data_ready)
    else $error("transfer too long");
  a_sync_pull_only: assert property (sync_out == 1'b0)
    else $error("sync driven high");
endmodule : lmt_core_asserts

bind lmt_core lmt_core_asserts u_chk (.clk, .rst_n, .osc_tied_high, .clk_pin_out, .clk_pin_oe,
  .sync_out, .cmd_valid, .cmd_code, .cmd_arg, .data_valid, .data_ready, .backplane_out_0,
  .segment_out, .ladder_mid_bypass, .active_backplanes, .blink_mode, .in_bank, .out_bank,
  .data_pointer, .subaddr_count, .serial_if_init);
`default_nettype wire

// >>> lmt_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts of the LCD timing core.
// Assumes: Included by bare name from every design file that needs it.
// Notes: Definitions only.
`ifndef LMT_DEFINES_SVH
`define LMT_DEFINES_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define LMT_SEGMENTS 40
`define LMT_LAST_ADDR 6'h27

// ----------------------------------------
// Timing counts: frame divisors in timing ticks, oscillator half period in clock cycles
// ----------------------------------------
`define LMT_FRAME_DIV_NORMAL 12'hB40
`define LMT_FRAME_DIV_SAVE 12'h1E0
`define LMT_OSC_HALF_CYCLES 4'h4

// ----------------------------------------
// Command codes
// ----------------------------------------
`define LMT_CMD_MODE_SET 3'h0
`define LMT_CMD_LOAD_PTR 3'h1
`define LMT_CMD_DEV_SEL 3'h2
`define LMT_CMD_BANK_SEL 3'h3
`define LMT_CMD_BLINK 3'h4

// ----------------------------------------
// Mode set and bank select argument fields
// ----------------------------------------
`define LMT_ARG_MUX_LSB 0
`define LMT_ARG_HALF_BIT 2
`define LMT_ARG_ENABLE_BIT 3
`define LMT_ARG_SAVE_BIT 4
`define LMT_ARG_IN_BANK_BIT 1
`define LMT_ARG_OUT_BANK_BIT 0

// ----------------------------------------
// Reset values and drive levels (0 = top supply, 3 = panel supply)
// ----------------------------------------
`define LMT_RST_HALF_BIAS 1'b0
`define LMT_LVL_TOP 2'h0
`define LMT_LVL_ONE 2'h1
`define LMT_LVL_TWO 2'h2
`define LMT_LVL_BOT 2'h3

`endif

// >>> lmt_frame_div.sv
// Purpose: Frame divider: splits each frame into two halves of one slot per backplane.
// Assumes: tick marks one edge of the selected timing clock.
// Notes: Slot length is the frame divisor over twice the multiplex ratio.
`include "lmt_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module lmt_frame_div
  import lmt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic power_save,
  input wire lmt_mux_type mux,
  input wire logic resync,
  output logic slot_start,
  output logic [1:0] phase,
  output logic half
);

  lmt_div_state_type s;
  lmt_div_state_type next_s;
  logic [11:0] base;
  logic [11:0] slot_len;

  // ----------------------------------------
  // Slot length per mode
  // ----------------------------------------
  always_comb
  begin
    base = power_save ? `LMT_FRAME_DIV_SAVE : `LMT_FRAME_DIV_NORMAL; // [R12] [R13]
    unique case (mux)
      LMT_MUX_STATIC: slot_len = base >> 1;
      LMT_MUX_2: slot_len = base >> 2;
      LMT_MUX_3: slot_len = base / 12'h006;
      LMT_MUX_4: slot_len = base >> 3;
    endcase
  end

  // ----------------------------------------
  // Slot counter, phase and frame half
  // ----------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.slot_start = 1'b0;
    if (resync)
    begin
      // Restart aligned with the other drivers in the cascade
      next_s.cnt = 12'h000; // [R16]
      next_s.phase = 2'h0;
      next_s.half = 1'b0;
      next_s.slot_start = 1'b1;
    end
    else if (tick)
    begin
      if (s.cnt >= slot_len - 12'h001)
      begin
        next_s.cnt = 12'h000;
        next_s.slot_start = 1'b1;
        if (s.phase >= 2'(mux))
        begin
          next_s.phase = 2'h0;
          next_s.half = ~s.half; // [R21]
        end
        else
          next_s.phase = s.phase + 2'h1;
      end
      else
        next_s.cnt = s.cnt + 12'h001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign slot_start = s.slot_start;
  assign phase = s.phase;
  assign half = s.half;

endmodule : lmt_frame_div
`default_nettype wire

// >>> lmt_host_model.sv
// Purpose: Host side model: decoded commands, display words, external clock.
// Assumes: Tasks are entered at a falling clock edge.
// Notes: Released cmd_arg and data_word carry the inverse of the last value.
`timescale 1ns/1ns
`default_nettype none
module lmt_host_model
#(
  parameter int SETTLE = 8
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic data_ready,
  output var logic cmd_valid,
  output var logic [2:0] cmd_code,
  output var logic [7:0] cmd_arg,
  output var logic data_valid,
  output var logic [3:0] data_word,
  output var logic clk_pin_in
);
  int since = 0;

  // Idle bus and a free-running external clock, one tick per two cycles
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code = 3'h0;
    cmd_arg = 8'h00;
    data_valid = 1'b0;
    data_word = 4'h0;
    clk_pin_in = 1'b0;
  end
  always @(negedge clk) clk_pin_in <= ~clk_pin_in;
  always @(posedge clk) since <= rst_n ? since + 1 : 0;

  task automatic send_cmd(input logic [2:0] code, input logic [7:0] arg);
    while (since < SETTLE) @(negedge clk);
    cmd_code = code;
    cmd_arg = arg;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_arg = ~arg;
    // Idle cycle so a following call never re-raises valid in this time step
    @(negedge clk);
  endtask : send_cmd

  // Ready is registered, so its level here is what the next edge sees
  task automatic send_word(input logic [3:0] w, output logic ok);
    int i;
    ok = 1'b0;
    while (since < SETTLE) @(negedge clk);
    data_word = w;
    data_valid = 1'b1;
    for (i = 0; i < 100 && !ok; i++)
    begin
      ok = data_ready;
      @(negedge clk);
    end
    data_valid = 1'b0;
    data_word = ~w;
    @(negedge clk);
  endtask : send_word
endmodule : lmt_host_model
`default_nettype wire

// >>> lmt_pkg.sv
// Purpose: Types shared by the LCD timing core modules.
// Assumes: Constants come from lmt_defines.svh.
// Notes: lmt_frame_div and lmt_ram_latch keep all of their state in one struct declared here.
package lmt_pkg;

  // ----------------------------------------
  // Drive configuration
  // ----------------------------------------
  typedef enum logic [1:0] {LMT_MUX_STATIC, LMT_MUX_2, LMT_MUX_3, LMT_MUX_4} lmt_mux_type;

  // ----------------------------------------
  // Module state
  // ----------------------------------------
  typedef struct packed {
    logic [11:0] cnt;
    logic [1:0] phase;
    logic half;
    logic slot_start;
  } lmt_div_state_type;

  typedef struct packed {
    logic [39:0][3:0] ram;
    logic [39:0] shadow;
    logic [39:0] latch;
    logic [5:0] idx;
    logic [1:0] bit_sel;
    logic busy;
    logic ready;
    logic done;
  } lmt_lat_state_type;

endpackage : lmt_pkg

// >>> lmt_ram_latch.sv
// Purpose: Display RAM with a shift-style transfer into the display latch.
// Assumes: One reload is started per multiplex slot.
// Notes: Writes stall while a transfer is running, so a data word is held, never lost.
`include "lmt_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module lmt_ram_latch
  import lmt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load_start,
  input wire logic [1:0] load_bit,
  input wire logic wr_valid,
  input wire logic wr_store,
  input wire logic [5:0] wr_addr,
  input wire logic [3:0] wr_data,
  input wire logic [3:0] wr_mask,
  output logic wr_ready,
  output logic load_done,
  output logic [39:0] latch
);

  lmt_lat_state_type s;
  lmt_lat_state_type next_s;

  // ----------------------------------------
  // Transfer walks one address per cycle, then swaps the latch in whole
  // ----------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    if (s.busy)
    begin
      next_s.shadow[s.idx] = s.ram[s.idx][s.bit_sel]; // [R19]
      if (s.idx == `LMT_LAST_ADDR)
      begin
        next_s.latch = next_s.shadow; // [R17]
        next_s.busy = 1'b0;
        next_s.ready = 1'b1;
        next_s.done = 1'b1;
      end
      else
        next_s.idx = s.idx + 6'h01;
    end
    else if (load_start)
    begin
      next_s.busy = 1'b1;
      next_s.ready = 1'b0; // [R18]
      next_s.idx = 6'h00;
      next_s.bit_sel = load_bit;
    end
    // Store only when ready; stalled writes wait at the port
    if (wr_valid && s.ready && wr_store && wr_addr <= `LMT_LAST_ADDR)
      next_s.ram[wr_addr] = (s.ram[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
    if (load_start && !s.busy)
      next_s.ready = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.ready <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign wr_ready = s.ready;
  assign load_done = s.done;
  assign latch = s.latch;

endmodule : lmt_ram_latch
`default_nettype wire

// >>> tb.sv
// Purpose: Self-checking bench of the LCD timing core.
// Assumes: External clock mode except in the oscillator test.
// Notes: One external tick per two cycles, so a frame is twice its tick count.
`include "lmt_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic osc_tied_high = 1'b1;
  logic [2:0] hw_subaddr = 3'h0;
  logic clk_pin_in, clk_pin_out, clk_pin_oe, sync_in, sync_out, sync_oe;
  logic cmd_valid, data_valid, data_ready, ladder_mid_bypass, display_enable, power_save;
  logic in_bank, out_bank, serial_if_init, ok;
  logic [2:0] cmd_code, active_backplanes, subaddr_count;
  logic [7:0] cmd_arg;
  logic [3:0] data_word, m;
  logic [1:0] backplane_out_0, backplane_out_1, backplane_out_2, backplane_out_3;
  logic [1:0] blink_mode, p;
  logic [79:0] segment_out;
  logic [5:0] data_pointer;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int a, b, i;

  // Clock, cycle stamp, and the pulled-up sync wire
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  assign sync_in = ~sync_oe;

  lmt_core DUT (.clk, .rst_n, .osc_tied_high, .clk_pin_in, .clk_pin_out, .clk_pin_oe,
    .sync_in, .sync_out, .sync_oe, .hw_subaddr, .cmd_valid, .cmd_code, .cmd_arg,
    .data_valid, .data_word, .data_ready, .backplane_out_0, .backplane_out_1,
    .backplane_out_2, .backplane_out_3, .segment_out, .ladder_mid_bypass,
    .active_backplanes, .display_enable, .power_save, .blink_mode, .in_bank, .out_bank,
    .data_pointer, .subaddr_count, .serial_if_init);
  lmt_host_model host (.clk, .rst_n, .data_ready, .cmd_valid, .cmd_code, .cmd_arg,
    .data_valid, .data_word, .clk_pin_in);

  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  // Waits for a rise of the oscillator pin or of the sync pull
  task automatic wait_edge(input logic osc, output int at);
    logic prev;
    logic now;
    prev = osc ? clk_pin_out : sync_oe;
    for (int k = 0; k < 20000; k++)
    begin
      @(negedge clk);
      now = osc ? clk_pin_out : sync_oe;
      if (now && !prev)
      begin
        at = cyc;
        return;
      end
      prev = now;
    end
    fail_count++;
    $display("Error at %0t: edge never came", $time);
    complete_run();
  endtask : wait_edge

  task automatic chk_reset();
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    check(segment_out, 80'h0);
    check({backplane_out_0, backplane_out_1, backplane_out_2, backplane_out_3}, 80'h0);
    check({active_backplanes, ladder_mid_bypass}, 80'h8);
    check({blink_mode, in_bank, out_bank}, 80'h0);
    check({data_pointer, subaddr_count, serial_if_init}, 80'h1);
    rst_n = 1'b1;
  endtask : chk_reset

  // First frame after a mode change may be partial, so it is skipped
  task automatic frame_len(input logic [7:0] arg, input int exp);
    host.send_cmd(`LMT_CMD_MODE_SET, arg);
    wait_edge(1'b0, a);
    wait_edge(1'b0, a);
    wait_edge(1'b0, b);
    check(80'(b - a), 80'(exp));
    check({display_enable, power_save}, 80'({1'b1, arg[4]}));
  endtask : frame_len

  initial
  begin
    chk_reset();
    for (m = 4'h0; m < 4'h8; m++)
    begin
      host.send_cmd(`LMT_CMD_MODE_SET, {5'h01, m[2:0]});
      check(80'(active_backplanes), 80'({1'b0, m[1:0]}) + 80'h1);
      check(80'(ladder_mid_bypass), 80'(m[2] && m[1:0] != 2'h0));
    end
    host.send_cmd(3'h7, 8'h00);
    host.send_cmd(`LMT_CMD_BANK_SEL, 8'h03);
    host.send_cmd(`LMT_CMD_BLINK, 8'h02);
    check({active_backplanes, in_bank, out_bank, blink_mode}, 80'h4E);
    chk_reset();
    frame_len(8'h0B, 5760);
    frame_len(8'h1B, 960);
    // Burst of words starting at a slot start, so the transfer stalls it
    host.send_cmd(`LMT_CMD_MODE_SET, 8'h08);
    host.send_cmd(`LMT_CMD_LOAD_PTR, 8'h00);
    wait_edge(1'b0, a);
    for (i = 0; i < 40; i++)
    begin
      host.send_word((i == 0) ? 4'hF : 4'h0, ok);
      check(80'(ok), 80'h1);
    end
    check({data_pointer, subaddr_count}, 80'h1);
    wait_edge(1'b0, a);
    wait_edge(1'b0, a);
    repeat (50) @(negedge clk);
    p = backplane_out_0;
    check(80'(segment_out[1:0] ^ p), 80'h3);
    check(80'(segment_out[3:2] ^ p), 80'h0);
    check({backplane_out_1, backplane_out_2, backplane_out_3}, 80'({3{p}}));
    repeat (2880) @(negedge clk);
    check(80'(backplane_out_0 ^ p), 80'h3);
    check(80'(segment_out[1:0] ^ backplane_out_0), 80'h3);
    osc_tied_high = 1'b0;
    @(negedge clk);
    check(80'(clk_pin_oe), 80'h1);
    wait_edge(1'b1, a);
    wait_edge(1'b1, b);
    check(80'(b - a), 80'h8);
    osc_tied_high = 1'b1;
    @(negedge clk);
    check(80'(clk_pin_oe), 80'h0);
    complete_run();
  end
endmodule : tb
`default_nettype wire
